// file: logic/blit_color_pattern_regs.sv
// Purpose: APB register bank for block-transfer colours, pattern and key
// Assumes: depth_65k and transparency_en come from elsewhere in the chip
// Notes: Every access phase takes two cycles; pready rises in the second
//
// Notes on behaviour
// - Background green is 6 bits; 256 colours use bits 2:0, 65K all.
// - Background blue is 5 bits; 256 colours use bits 1:0, 65K all.
// - Foreground red is 5 bits, resets to 1F, 256 colours use 2:0.
// - Foreground green is 6 bits, resets to 3F, 256 colours use 2:0.
// - Foreground blue is 5 bits, resets to 1F, 256 colours use 1:0.
// - Pattern format bit: clear is 8x8, set is 16x16; resets clear.
// - Pattern set number: four bits for 8x8, two low bits for 16x16.
// - Key red is 5 bits, resets to zero, 3 or 5 bits by depth.
// - Key green is 6 bits, resets to zero, 3 or 6 bits by depth.
// - Key blue is 5 bits, resets to zero, 2 or 5 bits by depth.
// - Transparency enable turns key colour comparison on; clear means none.
`timescale 1ns/100ps
`default_nettype none

module blit_color_pattern_regs #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Display configuration
    input wire logic depth_65k,
    input wire logic transparency_en,
    // Pixel under test for transparent keying
    input wire logic [4:0] pixel_red,
    input wire logic [5:0] pixel_green,
    input wire logic [4:0] pixel_blue,
    // Settings to the block-transfer engine
    output logic [5:0] bg_green_out,
    output logic [4:0] bg_blue_out,
    output logic [4:0] fg_red_out,
    output logic [5:0] fg_green_out,
    output logic [4:0] fg_blue_out,
    output logic pattern_16x16_out,
    output logic [3:0] pattern_set_out,
    output logic [4:0] key_red_out,
    output logic [5:0] key_green_out,
    output logic [4:0] key_blue_out,
    output logic key_hit
);

    // Stored fields at their native widths, so unused bits cannot exist
    logic [5:0] bg_green_ff, nxt_bg_green;
    logic [4:0] bg_blue_ff, nxt_bg_blue;
    logic [4:0] fg_red_ff, nxt_fg_red;
    logic [5:0] fg_green_ff, nxt_fg_green;
    logic [4:0] fg_blue_ff, nxt_fg_blue;
    logic pat_fmt_ff, nxt_pat_fmt;
    logic [3:0] pat_set_ff, nxt_pat_set;
    logic [4:0] key_red_ff, nxt_key_red;
    logic [5:0] key_green_ff, nxt_key_green;
    logic [4:0] key_blue_ff, nxt_key_blue;
    // Bus answer
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    // Engine side outputs
    logic [5:0] bg_green_o_ff, nxt_bg_green_o;
    logic [4:0] bg_blue_o_ff, nxt_bg_blue_o;
    logic [4:0] fg_red_o_ff, nxt_fg_red_o;
    logic [5:0] fg_green_o_ff, nxt_fg_green_o;
    logic [4:0] fg_blue_o_ff, nxt_fg_blue_o;
    logic pat16_o_ff, nxt_pat16_o;
    logic [3:0] pat_set_o_ff, nxt_pat_set_o;
    logic [4:0] key_red_o_ff, nxt_key_red_o;
    logic [5:0] key_green_o_ff, nxt_key_green_o;
    logic [4:0] key_blue_o_ff, nxt_key_blue_o;
    logic key_hit_ff, nxt_key_hit;

    logic [ADDR_W-3:0] word_idx;
    logic addr_ok;
    logic [7:0] rd_val;
    logic wr_go;
    logic [7:0] wb;
    logic [4:0] px_r, px_b;
    logic [5:0] px_g;

    // Narrow a component to what the selected depth uses
    function automatic logic [5:0] depth_mask(input logic [5:0] v,
                                              input int keep,
                                              input logic full);
        logic [5:0] m;
        m = 6'h00;
        for (int i = 0; i < 6; i++) begin
            if (i < keep) begin
                m[i] = 1'b1;
            end
        end
        depth_mask = full ? v : (v & m);
    endfunction : depth_mask

    assign word_idx = paddr[ADDR_W-1:blit_colour_pkg::ADDR_LSB];
    assign wb = pwdata[7:0];
    // A write lands only on the edge that also completes the access
    assign wr_go = psel & penable & pready_ff & pwrite & addr_ok & pstrb[0];

    // Address decode and read mux; upper bits zero-extend
    always_comb begin
        addr_ok = 1'b1;
        rd_val = 8'h00;
        if (paddr[blit_colour_pkg::ADDR_LSB-1:0] != 2'b00) begin
            addr_ok = 1'b0;
        end else begin
            unique case (word_idx)
                (ADDR_W-2)'(blit_colour_pkg::IDX_BG_GREEN):
                    rd_val = {2'b00, bg_green_ff};
                (ADDR_W-2)'(blit_colour_pkg::IDX_BG_BLUE):
                    rd_val = {3'b000, bg_blue_ff};
                (ADDR_W-2)'(blit_colour_pkg::IDX_FG_RED):
                    rd_val = {3'b000, fg_red_ff};
                (ADDR_W-2)'(blit_colour_pkg::IDX_FG_GREEN):
                    rd_val = {2'b00, fg_green_ff};
                (ADDR_W-2)'(blit_colour_pkg::IDX_FG_BLUE):
                    rd_val = {3'b000, fg_blue_ff};
                (ADDR_W-2)'(blit_colour_pkg::IDX_PATTERN):
                    rd_val = {pat_fmt_ff, 3'b000, pat_set_ff};
                (ADDR_W-2)'(blit_colour_pkg::IDX_KEY_RED):
                    rd_val = {3'b000, key_red_ff};
                (ADDR_W-2)'(blit_colour_pkg::IDX_KEY_GREEN):
                    rd_val = {2'b00, key_green_ff};
                (ADDR_W-2)'(blit_colour_pkg::IDX_KEY_BLUE):
                    rd_val = {3'b000, key_blue_ff};
                default: addr_ok = 1'b0;
            endcase
        end
    end

    // Register file next state
    always_comb begin
        nxt_bg_green = bg_green_ff;
        nxt_bg_blue = bg_blue_ff;
        nxt_fg_red = fg_red_ff;
        nxt_fg_green = fg_green_ff;
        nxt_fg_blue = fg_blue_ff;
        nxt_pat_fmt = pat_fmt_ff;
        nxt_pat_set = pat_set_ff;
        nxt_key_red = key_red_ff;
        nxt_key_green = key_green_ff;
        nxt_key_blue = key_blue_ff;
        if (wr_go) begin
            unique case (word_idx)
                (ADDR_W-2)'(blit_colour_pkg::IDX_BG_GREEN):
                    nxt_bg_green = wb[5:0];
                (ADDR_W-2)'(blit_colour_pkg::IDX_BG_BLUE):
                    nxt_bg_blue = wb[4:0];
                (ADDR_W-2)'(blit_colour_pkg::IDX_FG_RED):
                    nxt_fg_red = wb[4:0];
                (ADDR_W-2)'(blit_colour_pkg::IDX_FG_GREEN):
                    nxt_fg_green = wb[5:0];
                (ADDR_W-2)'(blit_colour_pkg::IDX_FG_BLUE):
                    nxt_fg_blue = wb[4:0];
                (ADDR_W-2)'(blit_colour_pkg::IDX_PATTERN): begin
                    nxt_pat_fmt = wb[blit_colour_pkg::PAT_FMT_BIT];
                    nxt_pat_set = wb[3:0];
                end
                (ADDR_W-2)'(blit_colour_pkg::IDX_KEY_RED):
                    nxt_key_red = wb[4:0];
                (ADDR_W-2)'(blit_colour_pkg::IDX_KEY_GREEN):
                    nxt_key_green = wb[5:0];
                (ADDR_W-2)'(blit_colour_pkg::IDX_KEY_BLUE):
                    nxt_key_blue = wb[4:0];
                default: ;
            endcase
        end
    end

    // APB answer: one wait state keeps prdata registered without a
    // combinational path from paddr to the bus
    always_comb begin
        nxt_pready = psel & penable & ~pready_ff;
        nxt_pslverr = 1'b0;
        nxt_prdata = 32'h0000_0000;
        if (psel & penable & ~pready_ff) begin
            nxt_pslverr = ~addr_ok;
            if (~pwrite & addr_ok) begin
                nxt_prdata = {24'h00_0000, rd_val};
            end
        end
    end

    // Engine outputs; colour fields masked by colour depth, pattern set by format
    always_comb begin
        nxt_bg_green_o = depth_mask(bg_green_ff, blit_colour_pkg::G256_W,
                                    depth_65k);
        nxt_bg_blue_o = 5'(depth_mask({1'b0, bg_blue_ff},
                            blit_colour_pkg::B256_W, depth_65k));
        nxt_fg_red_o = 5'(depth_mask({1'b0, fg_red_ff},
                            blit_colour_pkg::R256_W, depth_65k));
        nxt_fg_green_o = depth_mask(fg_green_ff, blit_colour_pkg::G256_W,
                                    depth_65k);
        nxt_fg_blue_o = 5'(depth_mask({1'b0, fg_blue_ff},
                            blit_colour_pkg::B256_W, depth_65k));
        nxt_key_red_o = 5'(depth_mask({1'b0, key_red_ff},
                            blit_colour_pkg::R256_W, depth_65k));
        nxt_key_green_o = depth_mask(key_green_ff, blit_colour_pkg::G256_W,
                                     depth_65k);
        nxt_key_blue_o = 5'(depth_mask({1'b0, key_blue_ff},
                            blit_colour_pkg::B256_W, depth_65k));
        nxt_pat16_o = pat_fmt_ff;
        // 16x16 patterns are four times larger, so only four sets fit
        nxt_pat_set_o = pat_fmt_ff ? {2'b00, pat_set_ff[1:0]}
                                   : pat_set_ff;
        // Pixel is narrowed the same way so unused bits cannot spoil a match
        px_r = 5'(depth_mask({1'b0, pixel_red}, blit_colour_pkg::R256_W,
                             depth_65k));
        px_g = depth_mask(pixel_green, blit_colour_pkg::G256_W, depth_65k);
        px_b = 5'(depth_mask({1'b0, pixel_blue}, blit_colour_pkg::B256_W,
                             depth_65k));
        nxt_key_hit = transparency_en & (px_r == nxt_key_red_o)
                      & (px_g == nxt_key_green_o)
                      & (px_b == nxt_key_blue_o);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bg_green_ff <= blit_colour_pkg::RST_BG_GREEN;
            bg_blue_ff <= blit_colour_pkg::RST_BG_BLUE;
            fg_red_ff <= blit_colour_pkg::RST_FG_RED;
            fg_green_ff <= blit_colour_pkg::RST_FG_GREEN;
            fg_blue_ff <= blit_colour_pkg::RST_FG_BLUE;
            pat_fmt_ff <= blit_colour_pkg::RST_PAT_FMT;
            pat_set_ff <= blit_colour_pkg::RST_PAT_SET;
            key_red_ff <= blit_colour_pkg::RST_KEY_RB;
            key_green_ff <= blit_colour_pkg::RST_KEY_GREEN;
            key_blue_ff <= blit_colour_pkg::RST_KEY_RB;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            bg_green_o_ff <= 6'h00;
            bg_blue_o_ff <= 5'h00;
            fg_red_o_ff <= 5'h00;
            fg_green_o_ff <= 6'h00;
            fg_blue_o_ff <= 5'h00;
            pat16_o_ff <= 1'b0;
            pat_set_o_ff <= 4'h0;
            key_red_o_ff <= 5'h00;
            key_green_o_ff <= 6'h00;
            key_blue_o_ff <= 5'h00;
            key_hit_ff <= 1'b0;
        end else begin
            bg_green_ff <= nxt_bg_green;
            bg_blue_ff <= nxt_bg_blue;
            fg_red_ff <= nxt_fg_red;
            fg_green_ff <= nxt_fg_green;
            fg_blue_ff <= nxt_fg_blue;
            pat_fmt_ff <= nxt_pat_fmt;
            pat_set_ff <= nxt_pat_set;
            key_red_ff <= nxt_key_red;
            key_green_ff <= nxt_key_green;
            key_blue_ff <= nxt_key_blue;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            bg_green_o_ff <= nxt_bg_green_o;
            bg_blue_o_ff <= nxt_bg_blue_o;
            fg_red_o_ff <= nxt_fg_red_o;
            fg_green_o_ff <= nxt_fg_green_o;
            fg_blue_o_ff <= nxt_fg_blue_o;
            pat16_o_ff <= nxt_pat16_o;
            pat_set_o_ff <= nxt_pat_set_o;
            key_red_o_ff <= nxt_key_red_o;
            key_green_o_ff <= nxt_key_green_o;
            key_blue_o_ff <= nxt_key_blue_o;
            key_hit_ff <= nxt_key_hit;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign bg_green_out = bg_green_o_ff;
    assign bg_blue_out = bg_blue_o_ff;
    assign fg_red_out = fg_red_o_ff;
    assign fg_green_out = fg_green_o_ff;
    assign fg_blue_out = fg_blue_o_ff;
    assign pattern_16x16_out = pat16_o_ff;
    assign pattern_set_out = pat_set_o_ff;
    assign key_red_out = key_red_o_ff;
    assign key_green_out = key_green_o_ff;
    assign key_blue_out = key_blue_o_ff;
    assign key_hit = key_hit_ff;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Outputs lag the stored field by one edge, so compare with its past
    AST_BG_GREEN_256: assert property (
        !depth_65k |=>
            bg_green_out == {3'b000, $past(bg_green_ff[2:0])})
        else $error("background green not narrowed to 3 bits");
    AST_BG_BLUE_65K: assert property (
        depth_65k |=> bg_blue_out == $past(bg_blue_ff))
        else $error("background blue not full width in 65K depth");
    AST_FG_RED_256: assert property (
        !depth_65k |=> fg_red_out[4:3] == 2'b00)
        else $error("foreground red upper bits leak in 256 colours");
    AST_FG_GREEN_WRITE: assert property (
        (wr_go && word_idx == (ADDR_W-2)'(blit_colour_pkg::IDX_FG_GREEN))
            |=> fg_green_ff == $past(pwdata[5:0]))
        else $error("foreground green write lost");
    AST_FG_BLUE_256: assert property (
        !depth_65k |=> fg_blue_out[4:2] == 3'b000)
        else $error("foreground blue upper bits leak in 256 colours");
    AST_PAT_FMT_FOLLOW: assert property (
        1'b1 |=> pattern_16x16_out == $past(pat_fmt_ff))
        else $error("pattern format output does not follow register");
    AST_PAT_SET_16: assert property (
        pattern_16x16_out |-> pattern_set_out[3:2] == 2'b00)
        else $error("pattern set exceeds two bits in 16x16 format");
    AST_KEY_RED_256: assert property (
        !depth_65k |=> key_red_out[4:3] == 2'b00)
        else $error("key red upper bits leak in 256 colours");
    AST_KEY_GREEN_256: assert property (
        !depth_65k |=> key_green_out[5:3] == 3'b000)
        else $error("key green upper bits leak in 256 colours");
    AST_KEY_BLUE_WRITE: assert property (
        (wr_go && word_idx == (ADDR_W-2)'(blit_colour_pkg::IDX_KEY_BLUE))
            ##1 depth_65k |=>
            key_blue_out == $past(key_blue_ff))
        else $error("key blue not passed through in 65K depth");
    AST_NO_KEY_WHEN_OFF: assert property (
        !transparency_en |=> !key_hit)
        else $error("key hit while transparency disabled");
    AST_READ_UPPER_ZERO: assert property (
        pready |-> prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    AST_ONE_WAIT: assert property (
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("access phase not answered in two cycles");

endmodule : blit_color_pattern_regs

`default_nettype wire

// file: logic/blit_colour_pkg.sv
// Purpose: Shared constants for the block-transfer colour and pattern bank
// Assumes: Register indices are byte-register numbers; byte address is 4x
// Notes: Field widths are the native component widths in 65K-colour depth
package blit_colour_pkg;

    // Register indices; the APB byte address is the index times four
    localparam logic [7:0] IDX_BG_GREEN = 8'h61;
    localparam logic [7:0] IDX_BG_BLUE = 8'h62;
    localparam logic [7:0] IDX_FG_RED = 8'h63;
    localparam logic [7:0] IDX_FG_GREEN = 8'h64;
    localparam logic [7:0] IDX_FG_BLUE = 8'h65;
    localparam logic [7:0] IDX_PATTERN = 8'h66;
    localparam logic [7:0] IDX_KEY_RED = 8'h67;
    localparam logic [7:0] IDX_KEY_GREEN = 8'h68;
    localparam logic [7:0] IDX_KEY_BLUE = 8'h69;
    localparam int ADDR_LSB = 2;

    // Component widths in 65K-colour depth
    localparam int RB_W = 5;
    localparam int G_W = 6;
    // Component widths used in 256-colour depth
    localparam int R256_W = 3;
    localparam int G256_W = 3;
    localparam int B256_W = 2;

    // Pattern register layout
    localparam int PAT_FMT_BIT = 7;
    localparam int PAT_SET_W = 4;
    localparam int PAT16_SET_W = 2;

    // Values after reset
    localparam logic [4:0] RST_BG_BLUE = 5'h00;
    localparam logic [5:0] RST_BG_GREEN = 6'h00;
    localparam logic [4:0] RST_FG_RED = 5'h1F;
    localparam logic [5:0] RST_FG_GREEN = 6'h3F;
    localparam logic [4:0] RST_FG_BLUE = 5'h1F;
    localparam logic RST_PAT_FMT = 1'b0;
    localparam logic [3:0] RST_PAT_SET = 4'h0;
    localparam logic [4:0] RST_KEY_RB = 5'h00;
    localparam logic [5:0] RST_KEY_GREEN = 6'h00;

endpackage : blit_colour_pkg

// file: tb/apb_host_model.sv
// Purpose: APB host that programs the colour bank for the bench
// Assumes: pready, prdata and pslverr are sampled at the rising edge
// Notes: Released address and data lines flip so stale values cannot pass
`timescale 1ns/100ps
`default_nettype none

module apb_host_model #(
    parameter int ADDR_W = 12
) (
    // Clock
    input wire logic pclk,
    // APB requester side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    // APB answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h0;
    end

    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
            input logic [31:0] wd, input logic [3:0] st,
            output logic [31:0] rd, output logic err, output bit ok);
        int n;
        ok = 1'b0;
        rd = 32'h0;
        err = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        // Bounded wait; the caller treats a missing answer as a failure
        for (n = 0; n < 16 && !ok; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                ok = 1'b1;
                rd = prdata;
                err = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~addr;
        pwdata <= ~wd;
        pstrb <= ~st;
    endtask : xfer
endmodule : apb_host_model

`default_nettype wire

// file: tb/tb_blit_color_pattern_regs.sv
// Purpose: Self-checking bench for the colour and pattern register bank
// Assumes: Engine outputs and key_hit lag their cause by one cycle
// Notes: Table rows cover every register in both colour depths
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) \
    begin \
        n_checks++; \
        if ((g) !== (e)) begin \
            miscompares++; \
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
        end \
    end

module tb_blit_color_pattern_regs;
    typedef struct packed {
        logic [7:0] idx; logic [7:0] wd; logic [7:0] rd;
        logic [7:0] o65; logic [7:0] o256;
    } row_t;
    typedef struct packed {
        logic d; logic en; logic [4:0] r; logic [5:0] g; logic [4:0] b;
        logic hit;
    } key_row_t;
    localparam row_t ROWS [10] = '{
        '{8'h61, 8'hFF, 8'h3F, 8'h3F, 8'h07},
        '{8'h62, 8'hFF, 8'h1F, 8'h1F, 8'h03},
        '{8'h63, 8'hEA, 8'h0A, 8'h0A, 8'h02},
        '{8'h64, 8'hD5, 8'h15, 8'h15, 8'h05},
        '{8'h65, 8'h16, 8'h16, 8'h16, 8'h02},
        '{8'h66, 8'hFF, 8'h8F, 8'h83, 8'h83},
        '{8'h66, 8'h0B, 8'h0B, 8'h0B, 8'h0B},
        '{8'h67, 8'h1D, 8'h1D, 8'h1D, 8'h05},
        '{8'h68, 8'h2A, 8'h2A, 8'h2A, 8'h02},
        '{8'h69, 8'hEE, 8'h0E, 8'h0E, 8'h02}};
    localparam logic [7:0] RST [9] = '{8'h00, 8'h00, 8'h1F, 8'h3F, 8'h1F,
        8'h00, 8'h00, 8'h00, 8'h00};
    // Key registers hold 1D, 2A, 0E once the table has run
    localparam key_row_t KEYS [5] = '{
        '{1'b1, 1'b1, 5'h1D, 6'h2A, 5'h0E, 1'b1},
        '{1'b1, 1'b0, 5'h1D, 6'h2A, 5'h0E, 1'b0},
        '{1'b0, 1'b1, 5'h05, 6'h02, 5'h02, 1'b1},
        '{1'b1, 1'b1, 5'h05, 6'h02, 5'h02, 1'b0},
        '{1'b0, 1'b1, 5'h1D, 6'h2A, 5'h0F, 1'b0}};

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic depth_65k, transparency_en, pattern_16x16_out, key_hit;
    logic [4:0] pixel_red, pixel_blue, bg_blue_out, fg_red_out, fg_blue_out;
    logic [4:0] key_red_out, key_blue_out;
    logic [5:0] pixel_green, bg_green_out, fg_green_out, key_green_out;
    logic [3:0] pattern_set_out;
    int miscompares;
    int n_checks;

    blit_color_pattern_regs #(.ADDR_W(12)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .depth_65k(depth_65k), .transparency_en(transparency_en),
        .pixel_red(pixel_red), .pixel_green(pixel_green),
        .pixel_blue(pixel_blue), .bg_green_out(bg_green_out),
        .bg_blue_out(bg_blue_out), .fg_red_out(fg_red_out),
        .fg_green_out(fg_green_out), .fg_blue_out(fg_blue_out),
        .pattern_16x16_out(pattern_16x16_out),
        .pattern_set_out(pattern_set_out), .key_red_out(key_red_out),
        .key_green_out(key_green_out), .key_blue_out(key_blue_out),
        .key_hit(key_hit));

    apb_host_model #(.ADDR_W(12)) host_u (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    task automatic conclude;
        if (miscompares == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    function automatic logic [11:0] addr_of(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : addr_of

    function automatic logic [7:0] eng_out(input logic [7:0] idx);
        case (idx)
            8'h61: return {2'h0, bg_green_out};
            8'h62: return {3'h0, bg_blue_out};
            8'h63: return {3'h0, fg_red_out};
            8'h64: return {2'h0, fg_green_out};
            8'h65: return {3'h0, fg_blue_out};
            8'h66: return {pattern_16x16_out, 3'h0, pattern_set_out};
            8'h67: return {3'h0, key_red_out};
            8'h68: return {2'h0, key_green_out};
            default: return {3'h0, key_blue_out};
        endcase
    endfunction : eng_out

    task automatic acc(input logic wr, input logic [11:0] a,
            input logic [7:0] d, input logic [3:0] st,
            output logic [31:0] v, output logic e);
        bit ok;
        host_u.xfer(wr, a, {24'h0, d}, st, v, e, ok);
        if (!ok) begin
            miscompares++;
            conclude();
        end
    endtask : acc

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial begin : main
        logic [31:0] v;
        logic e;
        int i;
        miscompares = 0;
        n_checks = 0;
        presetn = 1'b0;
        depth_65k = 1'b1;
        transparency_en = 1'b0;
        pixel_red = 5'h00;
        pixel_green = 6'h00;
        pixel_blue = 5'h00;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 9; i++) begin
            acc(1'b0, addr_of(8'h61 + 8'(i)), 8'h00, 4'hF, v, e);
            `CHK("reset read", {24'h0, RST[i]}, v);
            `CHK("reset out", RST[i], eng_out(8'h61 + 8'(i)));
        end
        for (i = 0; i < 10; i++) begin
            acc(1'b1, addr_of(ROWS[i].idx), ROWS[i].wd, 4'hF, v, e);
            acc(1'b0, addr_of(ROWS[i].idx), 8'h00, 4'hF, v, e);
            `CHK("readback", {24'h0, ROWS[i].rd}, v);
            // Drop to 256-colour depth, then back to 65K; the stored field keeps all its bits
            depth_65k <= 1'b0;
            repeat (3) @(posedge pclk);
            `CHK("out 256", ROWS[i].o256, eng_out(ROWS[i].idx));
            depth_65k <= 1'b1;
            repeat (3) @(posedge pclk);
            `CHK("out 65K", ROWS[i].o65, eng_out(ROWS[i].idx));
        end
        // Strobe off, then a misaligned write: neither may land
        acc(1'b1, addr_of(8'h63), 8'h1B, 4'hE, v, e);
        `CHK("strobe err", 1'b0, e);
        acc(1'b1, addr_of(8'h63) | 12'h001, 8'h1B, 4'hF, v, e);
        `CHK("misaligned err", 1'b1, e);
        acc(1'b0, addr_of(8'h60), 8'h00, 4'hF, v, e);
        `CHK("unmapped err", 1'b1, e);
        `CHK("unmapped data", 32'h0, v);
        acc(1'b0, addr_of(8'h63), 8'h00, 4'hF, v, e);
        `CHK("red kept", 32'h0A, v);
        for (i = 0; i < 5; i++) begin
            depth_65k <= KEYS[i].d;
            transparency_en <= KEYS[i].en;
            pixel_red <= KEYS[i].r;
            pixel_green <= KEYS[i].g;
            pixel_blue <= KEYS[i].b;
            repeat (3) @(posedge pclk);
            `CHK("key hit", KEYS[i].hit, key_hit);
        end
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK("out in reset", 5'h00, fg_red_out);
        presetn <= 1'b1;
        acc(1'b0, addr_of(8'h63), 8'h00, 4'hF, v, e);
        `CHK("red after reset", 32'h1F, v);
        `CHK("key after reset", 8'h00, eng_out(8'h67));
        conclude();
    end
endmodule : tb_blit_color_pattern_regs

`undef CHK
`default_nettype wire
